// File: rtl/usbrb_pkg.sv
// package: register map, field layout and carriers of the core read bridge
package usbrb_pkg;

  // register byte offsets on the lite bus
  localparam logic [7:0]  OFS_VALUE   = 8'h00;
  localparam logic [7:0]  OFS_REQUEST = 8'h04;
  localparam logic [7:0]  OFS_STATUS  = 8'h08;

  // request register fields
  localparam int unsigned REQ_BIT     = 31;
  localparam int unsigned ABORT_BIT   = 30;
  localparam int unsigned ADR_LSB     = 2;
  localparam int unsigned ADR_MSB     = 9;
  localparam int unsigned ADR_W       = 8;
  localparam int unsigned CORE_AW     = 10;

  // status register fields
  localparam int unsigned DONE_BIT    = 0;

  // reset values
  localparam logic [31:0] VALUE_RST   = 32'h0000_0000;
  localparam logic [7:0]  ADR_RST     = 8'h00;

  // bus responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // bridge to core: request side
  typedef struct packed {
    logic                 abort;
    logic                 rd_req;
    logic [CORE_AW-1:0]   addr;
  } usbrb_core_req_t;

  // core to bridge: answer side
  typedef struct packed {
    logic                 ack;
    logic [31:0]          data;
  } usbrb_core_rsp_t;

endpackage

// File: rtl/usbrb_hold.sv
// one-entry holding register for a lite bus channel
`timescale 1ns/10ps
`default_nettype none
module usbrb_hold #(
  parameter int unsigned W = 8
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_nrst,
  input  wire logic         i_valid,
  input  wire logic [W-1:0] i_data,
  input  wire logic         i_take,
  output var  logic         o_ready,
  output var  logic         o_full,
  output var  logic [W-1:0] o_data
);

  // full and ready move together; the entry waits for the consumer
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_full  <= 1'b0;
      o_ready <= 1'b1;
    end
    else if (i_take)
    begin
      o_full  <= 1'b0;
      o_ready <= 1'b1;
    end
    else if (i_valid && o_ready)
    begin
      o_full  <= 1'b1;
      o_ready <= 1'b0;
    end
  end

  // payload capture on the handshake
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_data <= '0;
    else if (i_valid && o_ready)
      o_data <= i_data;
  end

endmodule
`default_nettype wire

// File: rtl/usbrb_sticky.sv
// sticky flag where a set always wins over a clear in the same cycle
`timescale 1ns/10ps
`default_nettype none
module usbrb_sticky (
  input  wire logic i_core_clk,
  input  wire logic i_nrst,
  input  wire logic i_set,
  input  wire logic i_clr,
  output var  logic o_flag
);

  // set has priority so no event is lost
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_flag <= 1'b0;
    else if (i_set)
      o_flag <= 1'b1;
    else if (i_clr)
      o_flag <= 1'b0;
  end

endmodule
`default_nettype wire

// File: rtl/usbrb_bridge.sv
// lite bus slave that reads usb device core registers indirectly
`timescale 1ns/10ps
`default_nettype none
module usbrb_bridge (
  input  wire logic                       i_core_clk,
  input  wire logic                       i_nrst,
  input  wire logic [7:0]                 i_s_axi_awaddr,
  input  wire logic                       i_s_axi_awvalid,
  output var  logic                       o_s_axi_awready,
  input  wire logic [31:0]                i_s_axi_wdata,
  input  wire logic [3:0]                 i_s_axi_wstrb,
  input  wire logic                       i_s_axi_wvalid,
  output var  logic                       o_s_axi_wready,
  output var  logic [1:0]                 o_s_axi_bresp,
  output var  logic                       o_s_axi_bvalid,
  input  wire logic                       i_s_axi_bready,
  input  wire logic [7:0]                 i_s_axi_araddr,
  input  wire logic                       i_s_axi_arvalid,
  output var  logic                       o_s_axi_arready,
  output var  logic [31:0]                o_s_axi_rdata,
  output var  logic [1:0]                 o_s_axi_rresp,
  output var  logic                       o_s_axi_rvalid,
  input  wire logic                       i_s_axi_rready,
  output var  usbrb_pkg::usbrb_core_req_t o_core_req,
  input  wire usbrb_pkg::usbrb_core_rsp_t i_core_rsp,
  input  wire logic                       i_core_wr_busy,
  output var  logic                       o_read_done
);

  logic                             aw_full;
  logic [7:0]                       aw_addr;
  logic                             w_full;
  logic [35:0]                      w_word;
  logic [31:0]                      wdata;
  logic [3:0]                       wstrb;
  logic                             wr_do;
  logic                             wr_req_hit;
  logic                             wr_sts_hit;
  logic                             wr_mapped;
  logic                             sw_start;
  logic                             sw_abort;
  logic                             rd_done;
  logic                             busy;
  logic                             abort_q;
  logic                             abort_clr;
  logic                             done_q;
  logic                             done_clr;
  logic                             rd_pending_q;
  logic [usbrb_pkg::ADR_W-1:0]      adr_q;
  logic [31:0]                      value_q;
  logic [31:0]                      req_view;
  logic [31:0]                      rd_mux;
  logic                             rd_mapped;

  // write address and write data are caught independently
  usbrb_hold #(
    .W (8)
  ) u_aw_hold (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_valid    (i_s_axi_awvalid),
    .i_data     (i_s_axi_awaddr),
    .i_take     (wr_do),
    .o_ready    (o_s_axi_awready),
    .o_full     (aw_full),
    .o_data     (aw_addr)
  );

  usbrb_hold #(
    .W (36)
  ) u_w_hold (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_valid    (i_s_axi_wvalid),
    .i_data     ({i_s_axi_wstrb, i_s_axi_wdata}),
    .i_take     (wr_do),
    .o_ready    (o_s_axi_wready),
    .o_full     (w_full),
    .o_data     (w_word)
  );

  // write decode once both halves are present and the response slot is free
  assign wdata      = w_word[31:0];
  assign wstrb      = w_word[35:32];
  assign wr_do      = aw_full && w_full && !o_s_axi_bvalid;
  assign wr_req_hit = wr_do && (aw_addr[7:2] == usbrb_pkg::OFS_REQUEST[7:2]);
  assign wr_sts_hit = wr_do && (aw_addr[7:2] == usbrb_pkg::OFS_STATUS[7:2]);
  assign wr_mapped  = (aw_addr[7:2] == usbrb_pkg::OFS_VALUE[7:2]) || (aw_addr[7:2] == usbrb_pkg::OFS_REQUEST[7:2])
                   || (aw_addr[7:2] == usbrb_pkg::OFS_STATUS[7:2]);

  // request bit reads 1 while a read is pending or the core is writing
  assign busy = rd_pending_q || i_core_wr_busy;

  // software actions on the request register
  assign sw_abort = wr_req_hit && wstrb[3] && wdata[usbrb_pkg::ABORT_BIT];
  assign sw_start = wr_req_hit && wstrb[3] && wdata[usbrb_pkg::REQ_BIT] && !wdata[usbrb_pkg::ABORT_BIT]
                 && !busy && !abort_q;

  assign rd_done  = rd_pending_q && i_core_rsp.ack && !abort_q;

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      rd_pending_q <= 1'b0;
    else if (sw_abort || abort_q)
      rd_pending_q <= 1'b0;
    else if (sw_start)
      rd_pending_q <= 1'b1;
    else if (rd_done)
      rd_pending_q <= 1'b0;
  end

  // word address field, byte lanes honoured
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      adr_q <= usbrb_pkg::ADR_RST;
    else if (wr_req_hit && !rd_pending_q)
    begin
      if (wstrb[0])
        adr_q[5:0] <= wdata[7:2];
      if (wstrb[1])
        adr_q[7:6] <= wdata[9:8];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      value_q <= usbrb_pkg::VALUE_RST;
    else if (rd_done)
      value_q <= i_core_rsp.data;
  end

  // completion sets the done flag, written 1 clears it
  assign done_clr = wr_sts_hit && wstrb[0] && wdata[usbrb_pkg::DONE_BIT];

  usbrb_sticky u_done (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_set      (rd_done),
    .i_clr      (done_clr),
    .o_flag     (done_q)
  );

  // abort clears itself once the core write has stopped
  assign abort_clr = abort_q && !i_core_wr_busy;

  usbrb_sticky u_abort (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_set      (sw_abort),
    .i_clr      (abort_clr),
    .o_flag     (abort_q)
  );

  // core request carrier, all fields straight from flops
  assign o_core_req = '{abort:  abort_q,
                        rd_req: rd_pending_q,
                        addr:   {adr_q, 2'b00}};
  assign o_read_done       = done_q;

  // write response
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp  <= usbrb_pkg::RESP_OKAY;
    end
    else if (wr_do)
    begin
      o_s_axi_bvalid <= 1'b1;
      o_s_axi_bresp  <= wr_mapped ? usbrb_pkg::RESP_OKAY : usbrb_pkg::RESP_SLVERR;
    end
    else if (i_s_axi_bready)
      o_s_axi_bvalid <= 1'b0;
  end

  // request bit mirrors a pending read or core write activity
  always_comb
  begin
    req_view                                             = '0;
    req_view[usbrb_pkg::REQ_BIT]                         = busy;
    req_view[usbrb_pkg::ABORT_BIT]                       = abort_q;
    req_view[usbrb_pkg::ADR_MSB:usbrb_pkg::ADR_LSB]      = adr_q;
  end

  // read data selection; reserved bits read as zero
  always_comb
  begin
    rd_mux    = '0;
    rd_mapped = 1'b1;
    unique case (i_s_axi_araddr[7:2])
      usbrb_pkg::OFS_VALUE[7:2]:   rd_mux = value_q;
      usbrb_pkg::OFS_REQUEST[7:2]: rd_mux = req_view;
      usbrb_pkg::OFS_STATUS[7:2]:  rd_mux[usbrb_pkg::DONE_BIT] = done_q;
      default:                     rd_mapped = 1'b0;
    endcase
  end

  // read channel: one outstanding read, answer one cycle after the address
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_rdata   <= '0;
      o_s_axi_rresp   <= usbrb_pkg::RESP_OKAY;
    end
    else if (i_s_axi_arvalid && o_s_axi_arready)
    begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid  <= 1'b1;
      o_s_axi_rdata   <= rd_mux;
      o_s_axi_rresp   <= rd_mapped ? usbrb_pkg::RESP_OKAY : usbrb_pkg::RESP_SLVERR;
    end
    else if (o_s_axi_rvalid && i_s_axi_rready)
    begin
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid  <= 1'b0;
    end
  end

  // loaded word equals the core answer
  value_load_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    rd_done |=> value_q == $past(i_core_rsp.data))
    else $error("read value not loaded from core answer");

  // value stays put without a completion
  value_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    !rd_done |=> $stable(value_q))
    else $error("read value changed without a completed read");

  // accepted start raises the core request
  read_issue_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    sw_start |=> o_core_req.rd_req
      && o_core_req.addr[9:8] == ($past(wstrb[1]) ? $past(wdata[9:8]) : $past(adr_q[7:6]))
      && o_core_req.addr[7:2] == ($past(wstrb[0]) ? $past(wdata[7:2]) : $past(adr_q[5:0])))
    else $error("core read not issued");

  no_start_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    !rd_pending_q && !sw_start |=> !o_core_req.rd_req)
    else $error("core read issued without a start");

  // completion clears request and sets done
  done_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    rd_done && !sw_abort |=> !rd_pending_q && done_q)
    else $error("completion did not clear request or set done");

  done_w1c_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    done_clr && !rd_done |=> !o_read_done)
    else $error("done flag not cleared by software");

  busy_view_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    i_core_wr_busy |-> req_view[usbrb_pkg::REQ_BIT])
    else $error("request bit low during core write");

  // bus read shows busy during a core write
  busy_read_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    i_s_axi_arvalid && o_s_axi_arready && i_s_axi_araddr[7:2] == usbrb_pkg::OFS_REQUEST[7:2] && i_core_wr_busy
    |=> o_s_axi_rdata[usbrb_pkg::REQ_BIT])
    else $error("busy not returned on the bus");

  // abort removes the request within one cycle and keeps it off one cycle more unless the abort bit has cleared
  abort_kill_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    sw_abort |=> !rd_pending_q ##1 (!rd_pending_q || !abort_q))
    else $error("abort left a core read pending");

  // abort returns to zero once the core is idle
  abort_self_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    abort_q && !i_core_wr_busy && !sw_abort |=> !abort_q)
    else $error("abort bit did not clear itself");

  // an answer during abort neither loads nor signals done
  abort_drop_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    abort_q && !done_q |=> !done_q && $stable(value_q))
    else $error("aborted access was reported as done");

  // core byte address is the field shifted by two
  addr_map_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    o_core_req.rd_req |-> (o_core_req.addr[1:0] == 2'b00 && o_core_req.addr[9:2] == adr_q)
      ##1 (!o_core_req.rd_req || $stable(o_core_req.addr)))
    else $error("core address does not follow the field");

endmodule
`default_nettype wire

// File: dv/usbrb_core_model.sv
// model of the usb device core register port: delayed read acks, write bursts
`timescale 1ns/10ps
`default_nettype none
module usbrb_core_model (
  input  wire logic                       i_core_clk,
  input  wire logic                       i_nrst,
  input  wire usbrb_pkg::usbrb_core_req_t i_req,
  input  wire logic [3:0]                 i_delay,
  input  wire logic                       i_wr_start,
  output var  usbrb_pkg::usbrb_core_rsp_t o_rsp,
  output var  logic                       o_wr_busy
);
  logic [3:0] cnt_q;
  logic [3:0] wr_q;
  logic       ack_d;
  // ack once the pending read has waited i_delay cycles
  assign ack_d = i_req.rd_req & ~i_req.abort & ~o_rsp.ack & (cnt_q == i_delay);
  assign o_wr_busy = (wr_q != 4'h0);
  // read answer; data toggles outside the ack cycle
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cnt_q <= 4'h0;
      o_rsp <= '0;
    end
    else
    begin
      o_rsp.ack <= ack_d;
      // junk data outside the ack cycle
      o_rsp.data <= ack_d ? {16'hc3a5, 6'h00, i_req.addr} : ~o_rsp.data;
      cnt_q <= !i_req.rd_req ? 4'h0 : (cnt_q == i_delay) ? cnt_q : cnt_q + 4'h1;
    end
  end
  // write burst: runs 15 cycles unless aborted
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      wr_q <= 4'h0;
    else if (i_req.abort)
      wr_q <= 4'h0;
    else if (i_wr_start)
      wr_q <= 4'hf;
    else if (wr_q != 4'h0)
      wr_q <= wr_q - 4'h1;
  end
endmodule
`default_nettype wire

// File: dv/usbrb_bridge_bench.sv
// self-checking bench of the core read bridge
`timescale 1ns/10ps
`default_nettype none
module usbrb_bridge_bench;
  logic                       clk = 1'b0;
  logic                       nrst = 1'b0;
  logic [7:0]                 awaddr = 8'h00;
  logic [7:0]                 araddr = 8'h00;
  logic [31:0]                wdata = 32'h0000_0000;
  logic [3:0]                 wstrb = 4'hf;
  logic                       awvalid = 1'b0;
  logic                       wvalid = 1'b0;
  logic                       bready = 1'b0;
  logic                       arvalid = 1'b0;
  logic                       rready = 1'b0;
  logic                       awready, wready, bvalid, arready, rvalid, wr_busy, read_done;
  logic [1:0]                 bresp, rresp;
  logic [31:0]                rdata;
  logic [3:0]                 delay = 4'h2;
  logic                       wr_start = 1'b0;
  usbrb_pkg::usbrb_core_req_t creq;
  usbrb_pkg::usbrb_core_rsp_t crsp;
  int                         error_cnt = 0;
  int                         n_checks = 0;
  logic [31:0]                last;
  logic [31:0]                d;
  logic [7:0]                 f;
  // free-running core clock
  always #2.5 clk = ~clk;
  usbrb_bridge dut (.i_core_clk(clk), .i_nrst(nrst), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
    .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
    .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_core_req(creq),
    .i_core_rsp(crsp), .i_core_wr_busy(wr_busy), .o_read_done(read_done));
  usbrb_core_model core (.i_core_clk(clk), .i_nrst(nrst), .i_req(creq), .i_delay(delay),
    .i_wr_start(wr_start), .o_rsp(crsp), .o_wr_busy(wr_busy));
  task automatic end_of_test();
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic limit(input int n);
    if (n >= 64)
    begin
      error_cnt++;
      $display("Error %0t bus wait timed out", $time);
      end_of_test();
    end
  endtask
  // lite write: both channels offered together, held until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 64);
    bready <= 1'b0;
    limit(n);
    chk_word({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 64);
    rready <= 1'b0;
    v = rdata;
    r = rresp;
    limit(n);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
    logic [31:0] v;
    logic [1:0]  r;
    rd(a, v, r);
    chk_word(v, ev);
    chk_word({30'h0, r}, {30'h0, er});
  endtask
  function automatic logic [31:0] start_word(input logic [7:0] fld);
    return {1'b1, 21'h0, fld, 2'b00};
  endfunction
  // word the core model returns for a field
  function automatic logic [31:0] core_word(input logic [7:0] fld);
    return {16'hc3a5, 6'h00, fld, 2'b00};
  endfunction
  // main sequence
  initial
  begin
    void'($urandom(18));
    d = 32'hffff_ffff;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rdc(usbrb_pkg::OFS_VALUE, 32'h0000_0000, usbrb_pkg::RESP_OKAY);
    rdc(usbrb_pkg::OFS_REQUEST, 32'h0000_0000, usbrb_pkg::RESP_OKAY);
    rdc(8'h0c, 32'h0000_0000, usbrb_pkg::RESP_SLVERR);
    wr(8'h10, 32'hffff_ffff, usbrb_pkg::RESP_SLVERR);
    wr(usbrb_pkg::OFS_REQUEST, 32'h0000_0204, usbrb_pkg::RESP_OKAY);
    #1 chk_flag(creq.rd_req, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      f = (i == 0) ? 8'h80 : (i == 1) ? 8'hcd : 8'(8'h80 + $urandom_range(77));
      delay <= 4'($urandom_range(15, 2));
      wr(usbrb_pkg::OFS_REQUEST, start_word(f), usbrb_pkg::RESP_OKAY);
      #1 chk_word({22'h0, creq.addr}, {22'h0, f, 2'b00});
      chk_flag(creq.rd_req, 1'b1);
      for (int k = 0; k < 30 && d[31] !== 1'b0; k++)
        rd(usbrb_pkg::OFS_REQUEST, d, last[1:0]);
      chk_flag(d[31], 1'b0);
      chk_word({24'h0, d[9:2]}, {24'h0, f});
      chk_flag(read_done, 1'b1);
      last = core_word(f);
      rdc(usbrb_pkg::OFS_VALUE, last, usbrb_pkg::RESP_OKAY);
      wr(usbrb_pkg::OFS_STATUS, 32'h0000_0001, usbrb_pkg::RESP_OKAY);
      rdc(usbrb_pkg::OFS_STATUS, 32'h0000_0000, usbrb_pkg::RESP_OKAY);
      d = 32'hffff_ffff;
    end
    delay <= 4'hf;
    wr(usbrb_pkg::OFS_REQUEST, start_word(8'h90), usbrb_pkg::RESP_OKAY);
    rdc(usbrb_pkg::OFS_REQUEST, 32'h8000_0240, usbrb_pkg::RESP_OKAY);
    wr(usbrb_pkg::OFS_REQUEST, 32'h4000_0240, usbrb_pkg::RESP_OKAY);
    #1 chk_flag(creq.rd_req, 1'b0);
    rdc(usbrb_pkg::OFS_REQUEST, 32'h0000_0240, usbrb_pkg::RESP_OKAY);
    repeat (20) @(posedge clk);
    chk_flag(read_done, 1'b0);
    rdc(usbrb_pkg::OFS_VALUE, last, usbrb_pkg::RESP_OKAY);
    wr_start <= 1'b1;
    @(posedge clk);
    wr_start <= 1'b0;
    rdc(usbrb_pkg::OFS_REQUEST, 32'h8000_0240, usbrb_pkg::RESP_OKAY);
    wr(usbrb_pkg::OFS_REQUEST, 32'h4000_0240, usbrb_pkg::RESP_OKAY);
    #1 chk_flag(creq.abort, 1'b1);
    rdc(usbrb_pkg::OFS_REQUEST, 32'h0000_0240, usbrb_pkg::RESP_OKAY);
    // low lanes only: field moves, bit 31 is masked off
    wstrb <= 4'h3;
    wr(usbrb_pkg::OFS_REQUEST, start_word(8'h88), usbrb_pkg::RESP_OKAY);
    wstrb <= 4'hf;
    #1 chk_flag(creq.rd_req, 1'b0);
    rdc(usbrb_pkg::OFS_REQUEST, 32'h0000_0220, usbrb_pkg::RESP_OKAY);
    wr(usbrb_pkg::OFS_VALUE, 32'hffff_ffff, usbrb_pkg::RESP_OKAY);
    rdc(usbrb_pkg::OFS_VALUE, last, usbrb_pkg::RESP_OKAY);
    // reset in mid-run with a core read in flight
    wr(usbrb_pkg::OFS_REQUEST, start_word(8'hcd), usbrb_pkg::RESP_OKAY);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    chk_flag(creq.rd_req, 1'b0);
    chk_flag(read_done, 1'b0);
    nrst <= 1'b1;
    rdc(usbrb_pkg::OFS_VALUE, 32'h0000_0000, usbrb_pkg::RESP_OKAY);
    rdc(usbrb_pkg::OFS_REQUEST, 32'h0000_0000, usbrb_pkg::RESP_OKAY);
    end_of_test();
  end
endmodule
`default_nettype wire
